// ===== rtl/pcl_dev.sv
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - three select bits route one of eight inputs
// - fixed channel map, threshold on channel one
// - host keeps test line high except pulses
// - cuff clamp zeroes raw cuff channel before test offset
// - filter clamp pins filtered output to reference
// - hundred step pot, select direction increment
// - trim inhibited without interlock jumper
// - wiper stored, restored at reset, power on loads default
// - address, data and enable strobe write latch
// - deflate one opens, inflate one closes
// - dump one closes, pump one runs
// - watchdog, overpressure mode, clamp bit meaning
// - neonatal bit halves trip point
// - system reset forces safe latch values
// - valves and pump gated by safety inputs
// - mode, clamp, size bits never gated
// - flags high idle, low after event
// - overpressure latches after qualification time
// - pneumatic reset pulse clears flags only
// - overpressure or failsafe low forces release
module pcl_dev #(
   parameter int          QUAL_CYCLES = pcl_pkg::QUAL_CYCLES,
   parameter logic [23:0] LATCH_MAP   = pcl_pkg::LATCH_MAP
) (
   // clock and reset
   input  wire logic                         CLK_SYS_I,
   input  wire logic                         RST_N_I,
   input  wire logic                         PWR_ON_I,
   // link to the module processor
   pcl_link_if.dev                           link,
   // analog channels as converter words
   input  wire logic [pcl_pkg::SAMPLE_W-1:0] AIN_MOTOR_LIMIT_I,
   input  wire logic [pcl_pkg::SAMPLE_W-1:0] AIN_MANIFOLD_RAW_I,
   input  wire logic [pcl_pkg::SAMPLE_W-1:0] AIN_MANIFOLD_REF_I,
   input  wire logic [pcl_pkg::SAMPLE_W-1:0] AIN_CUFF_FILT_I,
   input  wire logic [pcl_pkg::SAMPLE_W-1:0] AIN_CUFF_RAW_I,
   input  wire logic [pcl_pkg::SAMPLE_W-1:0] AIN_CUFF_REF_I,
   input  wire logic [pcl_pkg::SAMPLE_W-1:0] AIN_PUMP_CUR_I,
   // board pins, asynchronous
   input  wire logic                         OVP_RAW_I,
   input  wire logic                         OVC_RAW_I,
   input  wire logic                         JUMPER_I,
   // valve and pump drives
   output logic                              INFLATE_CLOSED_O,
   output logic                              DEFLATE_OPEN_O,
   output logic                              DUMP_CLOSED_O,
   output logic                              PUMP_ON_O,
   // mode outputs
   output logic                              WDOG_KICK_O,
   output logic                              OVP_MODE_O,
   output logic                              FLT_CLAMP_O,
   output logic                              NEONATAL_O,
   // threshold trim state
   output logic [6:0]                        WIPER_O,
   output logic [8:0]                        TRIP_MMHG_O
);
   localparam int SW = pcl_pkg::SAMPLE_W;
   localparam int QW = $clog2(QUAL_CYCLES + 1);
   localparam logic [QW-1:0] QMAX = QW'(QUAL_CYCLES);

   generate
      if (QUAL_CYCLES < 1) begin : g_bad_qual
         $error("QUAL_CYCLES must be at least one");
      end
   endgenerate

   logic [2:0]    s1_r, s2_r;
   logic [QW-1:0] qual_r, qual_nxt;
   logic          ovp_n_r, ovp_n_nxt, ovc_n_r, ovc_n_nxt;
   logic          prst_q_r, en_q_r, inc_q_r, sel_q_r;
   logic [7:0]    lat_r, lat_nxt, hit;
   logic [6:0]    wiper_r, wiper_nxt, nv_r, nv_nxt;
   logic [8:0]    trip_r, trip_nxt, base;
   logic [17:0]   prod;
   logic [SW-1:0] buf_r, buf_nxt, cuff;
   logic [SW-1:0] ain [8];
   logic [7:0]    out_r, out_nxt;
   logic          flt_ovp_n, prst_rise, en_rise, sel, step, store, safe;

   // pin synchronisers; only s2_r is read by logic
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
      end else begin
         s1_r <= {JUMPER_I, OVC_RAW_I, OVP_RAW_I};
         s2_r <= s1_r;
      end
   end

   // overpressure qualification and event flags
   always_comb begin
      flt_ovp_n = (qual_r != QMAX);
      prst_rise = link.pneu_reset & ~prst_q_r;
      qual_nxt  = '0;
      if (s2_r[0]) begin
         qual_nxt = flt_ovp_n ? qual_r + 1'b1 : qual_r;
      end
      ovp_n_nxt = ovp_n_r;
      ovc_n_nxt = ovc_n_r;
      if (prst_rise) begin
         ovp_n_nxt = 1'b1;
         ovc_n_nxt = 1'b1;
      end
      // a new event beats a clear in the same cycle
      if (!flt_ovp_n) begin
         ovp_n_nxt = 1'b0;
      end
      if (s2_r[1]) begin
         ovc_n_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         qual_r   <= '0;
         ovp_n_r  <= 1'b1;
         ovc_n_r  <= 1'b1;
         prst_q_r <= 1'b0;
      end else begin
         qual_r   <= qual_nxt;
         ovp_n_r  <= ovp_n_nxt;
         ovc_n_r  <= ovc_n_nxt;
         prst_q_r <= link.pneu_reset;
      end
   end

   // address decode per latch bit, duplicates allowed in the map
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_hit
         assign hit[gi] = (link.latch_addr == LATCH_MAP[3*gi +: 3]);
      end
   endgenerate

   // addressable latch; pneumatic reset does not touch it
   always_comb begin
      en_rise = link.pneu_enable_n & ~en_q_r;
      lat_nxt = lat_r;
      if (en_rise) begin
         for (int i = 0; i < 8; i++) begin
            if (hit[i]) begin
               lat_nxt[i] = link.latch_data;
            end
         end
      end
      if (!link.sys_reset_n) begin
         lat_nxt = (lat_nxt & ~pcl_pkg::LATCH_RST_MASK)
                   | (pcl_pkg::LATCH_RESET & pcl_pkg::LATCH_RST_MASK);
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         lat_r  <= pcl_pkg::LATCH_RESET;
         en_q_r <= 1'b1;
      end else begin
         lat_r  <= lat_nxt;
         en_q_r <= link.pneu_enable_n;
      end
   end

   // trim pot: steps on increment fall, stores on deselect
   always_comb begin
      sel       = ~link.pot_sel_n & s2_r[2];
      step      = sel & inc_q_r & ~link.pot_inc_n;
      store     = sel_q_r & ~sel & link.pot_inc_n;
      wiper_nxt = wiper_r;
      nv_nxt    = nv_r;
      if (step) begin
         if (link.pot_up_dn && wiper_r < 7'(pcl_pkg::POT_STEPS - 1)) begin
            wiper_nxt = wiper_r + 1'b1;
         end else if (!link.pot_up_dn && wiper_r != 7'h00) begin
            wiper_nxt = wiper_r - 1'b1;
         end
      end
      if (store) begin
         nv_nxt = wiper_r;
      end
      if (PWR_ON_I) begin
         nv_nxt = pcl_pkg::POT_DEFAULT;
      end
   end

   // nv_r survives RST_N_I, standing in for the nonvolatile cell
   always_ff @(posedge CLK_SYS_I) begin
      nv_r <= nv_nxt;
      if (!RST_N_I) begin
         wiper_r <= nv_r;
         inc_q_r <= 1'b1;
         sel_q_r <= 1'b0;
      end else begin
         wiper_r <= wiper_nxt;
         inc_q_r <= link.pot_inc_n;
         sel_q_r <= sel;
      end
   end

   // trip point, analog mux and gated drives
   always_comb begin
      base = lat_r[pcl_pkg::LB_NEONATAL] ? pcl_pkg::NEO_MMHG
                                         : pcl_pkg::ADULT_MMHG;
      prod = 18'(base) * (18'(pcl_pkg::TRIM_BASE) + 18'(wiper_r));
      trip_nxt = 9'(prod / 18'(pcl_pkg::TRIM_DIV));
      cuff = link.cuff_input_clamp_n ? AIN_CUFF_RAW_I : '0;
      if (!link.filter_test_pulse_n) begin
         cuff = cuff + pcl_pkg::TEST_OFFSET;
      end
      ain[pcl_pkg::CH_MOTOR_LIMIT]  = AIN_MOTOR_LIMIT_I;
      ain[pcl_pkg::CH_THRESHOLD]    = SW'(trip_r);
      ain[pcl_pkg::CH_MANIFOLD_RAW] = AIN_MANIFOLD_RAW_I;
      ain[pcl_pkg::CH_MANIFOLD_REF] = AIN_MANIFOLD_REF_I;
      ain[pcl_pkg::CH_CUFF_FILT]    = lat_r[pcl_pkg::LB_FLT_CLAMP]
                                      ? pcl_pkg::FILT_REF
                                      : AIN_CUFF_FILT_I;
      ain[pcl_pkg::CH_CUFF_RAW]     = cuff;
      ain[pcl_pkg::CH_CUFF_REF]     = AIN_CUFF_REF_I;
      ain[pcl_pkg::CH_PUMP_CURRENT] = AIN_PUMP_CUR_I;
      buf_nxt = ain[link.mux_select];
      safe = ~ovp_n_r | ~flt_ovp_n | ~link.failsafe_n;
      out_nxt = lat_r;
      if (safe) begin
         out_nxt[pcl_pkg::LB_INFLATE] = 1'b0;
         out_nxt[pcl_pkg::LB_DEFLATE] = 1'b1;
         out_nxt[pcl_pkg::LB_DUMP]    = 1'b0;
         out_nxt[pcl_pkg::LB_PUMP]    = 1'b0;
      end
      // mode, clamp and size bits pass ungated
      out_nxt[pcl_pkg::LB_OVP_MODE] = lat_r[pcl_pkg::LB_OVP_MODE];
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         trip_r <= pcl_pkg::ADULT_MMHG;
         buf_r  <= '0;
         out_r  <= pcl_pkg::LATCH_RESET;
      end else begin
         trip_r <= trip_nxt;
         buf_r  <= buf_nxt;
         out_r  <= out_nxt;
      end
   end

   assign link.buffered_analog_out = buf_r;
   assign link.overpressure_flag_n = ovp_n_r;
   assign link.overcurrent_flag_n  = ovc_n_r;
   assign INFLATE_CLOSED_O = out_r[pcl_pkg::LB_INFLATE];
   assign DEFLATE_OPEN_O   = out_r[pcl_pkg::LB_DEFLATE];
   assign DUMP_CLOSED_O    = out_r[pcl_pkg::LB_DUMP];
   assign PUMP_ON_O        = out_r[pcl_pkg::LB_PUMP];
   assign WDOG_KICK_O      = out_r[pcl_pkg::LB_WDOG];
   assign OVP_MODE_O       = out_r[pcl_pkg::LB_OVP_MODE];
   assign FLT_CLAMP_O      = out_r[pcl_pkg::LB_FLT_CLAMP];
   assign NEONATAL_O       = out_r[pcl_pkg::LB_NEONATAL];
   assign WIPER_O          = wiper_r;
   assign TRIP_MMHG_O      = trip_r;
endmodule : pcl_dev

// ===== rtl/pcl_host.sv
`timescale 1ns/1ps
module pcl_host #(
   parameter int PULSE_CYCLES = pcl_pkg::PULSE_CYCLES
) (
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_N_I,
   // link to the pneumatic board
   pcl_link_if.host         link,
   // axi4-lite slave
   input  wire logic [3:0]  S_AXI_AWADDR_I,
   input  wire logic        S_AXI_AWVALID_I,
   output logic             S_AXI_AWREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   input  wire logic        S_AXI_WVALID_I,
   output logic             S_AXI_WREADY_O,
   output logic [1:0]       S_AXI_BRESP_O,
   output logic             S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   input  wire logic [3:0]  S_AXI_ARADDR_I,
   input  wire logic        S_AXI_ARVALID_I,
   output logic             S_AXI_ARREADY_O,
   output logic [31:0]      S_AXI_RDATA_O,
   output logic [1:0]       S_AXI_RRESP_O,
   output logic             S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I
);
   localparam int TW = $clog2(PULSE_CYCLES + 1);

   generate
      if (PULSE_CYCLES < 1) begin : g_bad_pulse
         $error("PULSE_CYCLES must be at least one");
      end
   endgenerate

   logic              aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic [3:0]        awa_r, awa_nxt;
   logic [7:0]        wd_r, wd_nxt;
   logic [1:0]        br_r, br_nxt, rr_r, rr_nxt;
   logic [31:0]       rd_r, rd_nxt;
   logic [6:0]        ctrl_r, ctrl_nxt;
   logic [3:0]        arg_r, arg_nxt;
   logic [TW-1:0]     tm_r, tm_nxt;
   pcl_pkg::pcl_op_t  op_r, op_nxt;
   pcl_pkg::pcl_hst_t st_r, st_nxt;
   logic              last, do_wr;

   // register slave and command sequencer
   always_comb begin
      aw_nxt = aw_r;  w_nxt = w_r;  awa_nxt = awa_r;  wd_nxt = wd_r;
      bv_nxt = bv_r;  br_nxt = br_r;  rv_nxt = rv_r;  rr_nxt = rr_r;
      rd_nxt = rd_r;  ctrl_nxt = ctrl_r;  arg_nxt = arg_r;
      op_nxt = op_r;  st_nxt = st_r;  tm_nxt = tm_r;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
         aw_nxt  = 1'b1;
         awa_nxt = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
         w_nxt  = S_AXI_WSTRB_I[0];
         wd_nxt = S_AXI_WSTRB_I[0] ? S_AXI_WDATA_I[7:0] : 8'h00;
         w_nxt  = 1'b1;
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
         bv_nxt = 1'b0;
      end
      if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
         rv_nxt = 1'b0;
      end
      // sequencer: phases of PULSE_CYCLES each
      last = 1'b1;
      case (st_r)
         pcl_pkg::HS_IDLE: last = 1'b0;
         pcl_pkg::HS_P1:   last = (op_r == pcl_pkg::OP_PNEU_RST);
         pcl_pkg::HS_P2:   last = (op_r != pcl_pkg::OP_STEP);
         pcl_pkg::HS_P3:   last = 1'b1;
         default:          last = 1'b1;
      endcase
      if (st_r != pcl_pkg::HS_IDLE) begin
         if (tm_r != '0) begin
            tm_nxt = tm_r - 1'b1;
         end else begin
            tm_nxt = TW'(PULSE_CYCLES - 1);
            st_nxt = last ? pcl_pkg::HS_IDLE : pcl_pkg::pcl_hst_t'(st_r+1'b1);
         end
      end
      do_wr = aw_r && w_r && !bv_r;
      if (do_wr) begin
         aw_nxt = 1'b0;
         w_nxt  = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = pcl_pkg::RESP_OKAY;
         if (awa_r == pcl_pkg::REG_CTRL) begin
            ctrl_nxt = wd_r[6:0];
         end else if (awa_r == pcl_pkg::REG_CMD) begin
            // commands while busy or unknown are dropped
            if (st_r == pcl_pkg::HS_IDLE && wd_r[2:0] != 3'h0
                && wd_r[2:0] <= 3'(pcl_pkg::OP_PNEU_RST)) begin
               op_nxt  = pcl_pkg::pcl_op_t'(wd_r[2:0]);
               arg_nxt = wd_r[6:3];
               st_nxt  = pcl_pkg::HS_P1;
               tm_nxt  = TW'(PULSE_CYCLES - 1);
            end
         end else begin
            br_nxt = pcl_pkg::RESP_SLVERR;
         end
      end
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         rv_nxt = 1'b1;
         rr_nxt = pcl_pkg::RESP_OKAY;
         rd_nxt = 32'h0000_0000;
         case (S_AXI_ARADDR_I)
            pcl_pkg::REG_CTRL:   rd_nxt[6:0] = ctrl_r;
            pcl_pkg::REG_CMD:    rd_nxt[6:0] = {arg_r, 3'(op_r)};
            pcl_pkg::REG_STATUS: rd_nxt[2:0] = {link.overcurrent_flag_n,
                                   link.overpressure_flag_n,
                                   st_r != pcl_pkg::HS_IDLE};
            pcl_pkg::REG_SAMPLE: rd_nxt[pcl_pkg::SAMPLE_W-1:0] =
                                    link.buffered_analog_out;
            default:             rr_nxt = pcl_pkg::RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         aw_r <= 1'b0;  w_r <= 1'b0;  awa_r <= 4'h0;  wd_r <= 8'h00;
         bv_r <= 1'b0;  br_r <= 2'h0;  rv_r <= 1'b0;  rr_r <= 2'h0;
         rd_r <= 32'h0000_0000;
         ctrl_r <= pcl_pkg::CTRL_RESET;
         arg_r <= 4'h0;  op_r <= pcl_pkg::OP_NONE;
         st_r <= pcl_pkg::HS_IDLE;  tm_r <= '0;
      end else begin
         aw_r <= aw_nxt;  w_r <= w_nxt;  awa_r <= awa_nxt;  wd_r <= wd_nxt;
         bv_r <= bv_nxt;  br_r <= br_nxt;  rv_r <= rv_nxt;  rr_r <= rr_nxt;
         rd_r <= rd_nxt;  ctrl_r <= ctrl_nxt;  arg_r <= arg_nxt;
         op_r <= op_nxt;  st_r <= st_nxt;  tm_r <= tm_nxt;
      end
   end

   // bus handshakes: one write and one read at a time
   assign S_AXI_AWREADY_O = !aw_r && !bv_r;
   assign S_AXI_WREADY_O  = !w_r && !bv_r;
   assign S_AXI_BVALID_O  = bv_r;
   assign S_AXI_BRESP_O   = br_r;
   assign S_AXI_ARREADY_O = !rv_r;
   assign S_AXI_RVALID_O  = rv_r;
   assign S_AXI_RRESP_O   = rr_r;
   assign S_AXI_RDATA_O   = rd_r;

   // link levels decoded from registered state only
   assign link.mux_select          = ctrl_r[2:0];
   assign link.filter_test_pulse_n = ctrl_r[3];
   assign link.cuff_input_clamp_n  = ctrl_r[4];
   assign link.failsafe_n          = ctrl_r[5];
   assign link.sys_reset_n         = ctrl_r[pcl_pkg::CTRL_SYSRST];
   assign link.latch_addr          = arg_r[2:0];
   assign link.latch_data          = arg_r[3];
   assign link.pot_up_dn           = arg_r[3];
   assign link.pneu_enable_n = !(op_r == pcl_pkg::OP_LATCH
                                 && st_r == pcl_pkg::HS_P1);
   assign link.pneu_reset    = (op_r == pcl_pkg::OP_PNEU_RST
                                && st_r == pcl_pkg::HS_P1);
   // step deselects with increment low so that it does not store
   assign link.pot_sel_n = !((op_r == pcl_pkg::OP_STEP
                              && (st_r == pcl_pkg::HS_P1
                                  || st_r == pcl_pkg::HS_P2))
                             || (op_r == pcl_pkg::OP_STORE
                                 && st_r == pcl_pkg::HS_P1));
   assign link.pot_inc_n = !(op_r == pcl_pkg::OP_STEP
                             && (st_r == pcl_pkg::HS_P2
                                 || st_r == pcl_pkg::HS_P3));
endmodule : pcl_host

// ===== rtl/pcl_link_if.sv
`timescale 1ns/1ps
interface pcl_link_if #(parameter int SW = pcl_pkg::SAMPLE_W);
   logic [2:0]    mux_select;
   logic [SW-1:0] buffered_analog_out;
   logic          filter_test_pulse_n;
   logic          cuff_input_clamp_n;
   logic          pot_sel_n;
   logic          pot_up_dn;
   logic          pot_inc_n;
   logic [2:0]    latch_addr;
   logic          latch_data;
   logic          pneu_enable_n;
   logic          pneu_reset;
   logic          sys_reset_n;
   logic          failsafe_n;
   logic          overpressure_flag_n;
   logic          overcurrent_flag_n;

   modport dev (
      input  mux_select, filter_test_pulse_n, cuff_input_clamp_n,
             pot_sel_n, pot_up_dn, pot_inc_n, latch_addr, latch_data,
             pneu_enable_n, pneu_reset, sys_reset_n, failsafe_n,
      output buffered_analog_out, overpressure_flag_n, overcurrent_flag_n
   );
   modport host (
      output mux_select, filter_test_pulse_n, cuff_input_clamp_n,
             pot_sel_n, pot_up_dn, pot_inc_n, latch_addr, latch_data,
             pneu_enable_n, pneu_reset, sys_reset_n, failsafe_n,
      input  buffered_analog_out, overpressure_flag_n, overcurrent_flag_n
   );
endinterface : pcl_link_if

// ===== rtl/pcl_pkg.sv
package pcl_pkg;
   // link and timing
   localparam int SAMPLE_W      = 12;
   localparam int CLK_PERIOD_NS = 100;
   localparam int QUAL_MS       = 500;
   localparam int QUAL_CYCLES   = (QUAL_MS * 1000000) / CLK_PERIOD_NS;
   localparam int PULSE_NS      = 500;
   localparam int PULSE_CYCLES  = (PULSE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

   // analog mux channel numbers
   localparam logic [2:0] CH_MOTOR_LIMIT  = 3'h0;
   localparam logic [2:0] CH_THRESHOLD    = 3'h1;
   localparam logic [2:0] CH_MANIFOLD_RAW = 3'h2;
   localparam logic [2:0] CH_MANIFOLD_REF = 3'h3;
   localparam logic [2:0] CH_CUFF_FILT    = 3'h4;
   localparam logic [2:0] CH_CUFF_RAW     = 3'h5;
   localparam logic [2:0] CH_CUFF_REF     = 3'h6;
   localparam logic [2:0] CH_PUMP_CURRENT = 3'h7;

   // cuff channel offsets in converter counts
   localparam logic [SAMPLE_W-1:0] TEST_OFFSET = 12'h01f;
   localparam logic [SAMPLE_W-1:0] FILT_REF    = 12'h0a4;

   // addressable latch bit positions
   localparam int LB_INFLATE   = 0;
   localparam int LB_DEFLATE   = 1;
   localparam int LB_DUMP      = 2;
   localparam int LB_PUMP      = 3;
   localparam int LB_WDOG      = 4;
   localparam int LB_OVP_MODE  = 5;
   localparam int LB_FLT_CLAMP = 6;
   localparam int LB_NEONATAL  = 7;
   localparam logic [7:0]  LATCH_RESET = 8'h40;
   localparam logic [7:0]  LATCH_RST_MASK = 8'hcf;
   localparam logic [23:0] LATCH_MAP   = 24'hfa_c688;

   // threshold trim
   localparam int         POT_STEPS   = 100;
   localparam logic [6:0] POT_DEFAULT = 7'h32;
   localparam int         TRIM_BASE   = 450;
   localparam int         TRIM_DIV    = 500;
   localparam logic [8:0] ADULT_MMHG  = 9'h12c;
   localparam logic [8:0] NEO_MMHG    = 9'h096;

   // controller registers, byte addresses
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_CMD    = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_SAMPLE = 4'hc;
   localparam int CTRL_SYSRST = 6;
   localparam logic [6:0] CTRL_RESET = 7'h78;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      OP_NONE, OP_LATCH, OP_STEP, OP_STORE, OP_PNEU_RST
   } pcl_op_t;

   typedef enum logic [1:0] {HS_IDLE, HS_P1, HS_P2, HS_P3} pcl_hst_t;
endpackage : pcl_pkg

// ===== test/pcl_link_properties.sv
`timescale 1ns/1ps
module pcl_link_properties (
   // clock and reset
   input wire logic       CLK_SYS_I,
   input wire logic       RST_N_I,
   // link signals
   input wire logic [2:0] mux_select,
   input wire logic       filter_test_pulse_n,
   input wire logic       cuff_input_clamp_n,
   input wire logic       pot_sel_n,
   input wire logic       pot_up_dn,
   input wire logic       pot_inc_n,
   input wire logic [2:0] latch_addr,
   input wire logic       latch_data,
   input wire logic       pneu_enable_n,
   input wire logic       pneu_reset,
   input wire logic       sys_reset_n,
   input wire logic       failsafe_n,
   input wire logic       overpressure_flag_n,
   input wire logic       overcurrent_flag_n
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   // both pulses last five cycles with the default pulse length
   sequence strobe_low_s;
      !pneu_enable_n [*4] ##1 pneu_enable_n;
   endsequence
   sequence reset_high_s;
      pneu_reset [*4] ##1 !pneu_reset;
   endsequence
   strobe_width_a: assert property ($fell(pneu_enable_n) |=> strobe_low_s)
      else $error("latch strobe width wrong");
   addr_hold_a: assert property (!pneu_enable_n && !$past(pneu_enable_n)
      |-> $stable(latch_addr) && $stable(latch_data))
      else $error("latch address moved under strobe");
   pulse_width_a: assert property ($rose(pneu_reset) |=> reset_high_s)
      else $error("pneumatic reset pulse width wrong");
   inc_select_a: assert property ($fell(pot_inc_n) |-> !pot_sel_n)
      else $error("increment without select");
   sel_inc_a: assert property ($fell(pot_sel_n) |-> pot_inc_n)
      else $error("select fell with increment low");
   dir_hold_a: assert property (!pot_sel_n && !$past(pot_sel_n)
      |-> $stable(pot_up_dn))
      else $error("direction moved while selected");
   host_init_a: assert property ($past(!RST_N_I) |-> sys_reset_n
      && failsafe_n && filter_test_pulse_n && cuff_input_clamp_n
      && mux_select == 3'h0)
      else $error("host link lines wrong after reset");
   flag_init_a: assert property ($past(!RST_N_I)
      |-> overpressure_flag_n && overcurrent_flag_n)
      else $error("flags low after reset");
endmodule : pcl_link_properties

// ===== test/pneumatic_control_latch_bench.sv
`timescale 1ns/1ps
module pneumatic_control_latch_bench;
   logic        clk, rst_n, pwr_on, ovp, ovc, jmp;
   logic [11:0] ain [8];
   wire  [7:0]  drv;
   wire  [6:0]  wip;
   wire  [8:0]  trip;
   logic [3:0]  aw, ar;
   logic [31:0] wd, v;
   logic        awv, wv, brdy, arv, rrdy, ta, tw, tb;
   wire         awr, wr, bv, arr, rv;
   wire  [1:0]  br, rr;
   wire  [31:0] rd;
   int          n_fail, n_tests, w;
   logic [7:0]  lat;
   pcl_link_if lnk ();
   // short qualification keeps the overpressure run brief
   pcl_dev #(.QUAL_CYCLES(20)) u_pcl_dev (.CLK_SYS_I(clk), .RST_N_I(rst_n),
      .PWR_ON_I(pwr_on), .link(lnk.dev), .AIN_MOTOR_LIMIT_I(ain[0]),
      .AIN_MANIFOLD_RAW_I(ain[2]), .AIN_MANIFOLD_REF_I(ain[3]),
      .AIN_CUFF_FILT_I(ain[4]), .AIN_CUFF_RAW_I(ain[5]),
      .AIN_CUFF_REF_I(ain[6]), .AIN_PUMP_CUR_I(ain[7]), .OVP_RAW_I(ovp),
      .OVC_RAW_I(ovc), .JUMPER_I(jmp), .INFLATE_CLOSED_O(drv[0]),
      .DEFLATE_OPEN_O(drv[1]), .DUMP_CLOSED_O(drv[2]), .PUMP_ON_O(drv[3]),
      .WDOG_KICK_O(drv[4]), .OVP_MODE_O(drv[5]), .FLT_CLAMP_O(drv[6]),
      .NEONATAL_O(drv[7]), .WIPER_O(wip), .TRIP_MMHG_O(trip));
   pcl_host u_pcl_host (.CLK_SYS_I(clk), .RST_N_I(rst_n), .link(lnk.host),
      .S_AXI_AWADDR_I(aw), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
      .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
      .S_AXI_BREADY_I(brdy), .S_AXI_ARADDR_I(ar), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr),
      .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy));
   pcl_link_properties u_pcl_link_properties (.CLK_SYS_I(clk),
      .RST_N_I(rst_n), .mux_select(lnk.mux_select),
      .filter_test_pulse_n(lnk.filter_test_pulse_n),
      .cuff_input_clamp_n(lnk.cuff_input_clamp_n),
      .pot_sel_n(lnk.pot_sel_n), .pot_up_dn(lnk.pot_up_dn),
      .pot_inc_n(lnk.pot_inc_n), .latch_addr(lnk.latch_addr),
      .latch_data(lnk.latch_data), .pneu_enable_n(lnk.pneu_enable_n),
      .pneu_reset(lnk.pneu_reset), .sys_reset_n(lnk.sys_reset_n),
      .failsafe_n(lnk.failsafe_n),
      .overpressure_flag_n(lnk.overpressure_flag_n),
      .overcurrent_flag_n(lnk.overcurrent_flag_n));
   // clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, exp, input string nm);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // handshakes sampled at the falling edge, released after the rising one
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      aw <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do begin
         @(negedge clk);
         ta = awr;
         tw = wr;
         tb = bv;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end while (tb !== 1'b1);
   endtask : axw
   task automatic axr(input logic [3:0] a);
      ar <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do begin
         @(negedge clk);
         ta = arr;
         tb = rv;
         v = rd;
         @(posedge clk);
         if (ta) arv <= 1'b0;
      end while (tb !== 1'b1);
   endtask : axr
   // command, then poll busy so the link sequence has finished
   task automatic cmd(input int op, a, d);
      axw(pcl_pkg::REG_CMD, 32'(op + a * 8 + d * 64));
      do axr(pcl_pkg::REG_STATUS); while (v[0] !== 1'b0);
      repeat (3) @(posedge clk);
   endtask : cmd
   function automatic logic [31:0] mux_f(int ch);
      if (ch == 1) return (lat[7] ? 150 : 300) * (450 + w) / 500;
      if (ch == 4 && lat[6]) return 32'(pcl_pkg::FILT_REF);
      return 32'(ain[ch]);
   endfunction : mux_f
   task automatic summarize;
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end
   initial begin
      void'($urandom(13719));
      {rst_n, ovp, ovc, awv, wv, brdy, arv, rrdy} = 8'h00;
      {pwr_on, jmp} = 2'b11;
      {aw, ar, wd, n_fail, n_tests, w} = '0;
      foreach (ain[i]) ain[i] = 12'($urandom);
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      pwr_on <= 1'b0;
      @(posedge clk);
      lat = pcl_pkg::LATCH_RESET;
      w = 50;
      chk(drv, lat, "reset drives");
      chk(trip, 300, "trip");
      chk(wip, pcl_pkg::POT_DEFAULT, "start wiper");
      for (int i = 0; i < 16; i++) begin
         lat[i % 8] = 1'($urandom);
         cmd(1, i % 8, lat[i % 8]);
         chk(drv, lat, "latch");
      end
      for (int ch = 0; ch < 8; ch++) begin
         axw(pcl_pkg::REG_CTRL, 32'h78 + ch);
         axr(pcl_pkg::REG_SAMPLE);
         chk(v, mux_f(ch), "mux");
      end
      axw(pcl_pkg::REG_CTRL, 32'h65);
      axr(pcl_pkg::REG_SAMPLE);
      chk(v, 32'(pcl_pkg::TEST_OFFSET), "clamped cuff");
      axw(pcl_pkg::REG_CTRL, 32'h58);
      repeat (3) @(posedge clk);
      chk(drv, {lat[7:4], 4'h2}, "failsafe");
      axw(pcl_pkg::REG_CTRL, 32'h78);
      ovp <= 1'b1;
      ovc <= 1'b1;
      repeat (10) @(posedge clk);
      axr(pcl_pkg::REG_STATUS);
      chk(v[2:1], 2'b01, "early flags");
      repeat (30) @(posedge clk);
      axr(pcl_pkg::REG_STATUS);
      chk(v[2:1], 2'b00, "flags");
      chk(drv, {lat[7:4], 4'h2}, "overpressure");
      ovp <= 1'b0;
      ovc <= 1'b0;
      repeat (4) @(posedge clk);
      cmd(4, 0, 0);
      axr(pcl_pkg::REG_STATUS);
      chk(v[2:1], 2'b11, "cleared flags");
      chk(drv, lat, "after pulse");
      axw(pcl_pkg::REG_CTRL, 32'h38);
      repeat (4) @(posedge clk);
      lat = lat & ~pcl_pkg::LATCH_RST_MASK
         | pcl_pkg::LATCH_RESET & pcl_pkg::LATCH_RST_MASK;
      chk(drv, lat, "system reset");
      axw(pcl_pkg::REG_CTRL, 32'h79);
      cmd(2, 0, 1);
      cmd(2, 0, 0);
      cmd(2, 0, 0);
      w = 49;
      chk(wip, w, "wiper");
      cmd(3, 0, 0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(wip, w, "stored wiper");
      axw(pcl_pkg::REG_CTRL, 32'h79);
      axr(pcl_pkg::REG_SAMPLE);
      chk(v, mux_f(1), "trip level");
      jmp <= 1'b0;
      cmd(2, 0, 1);
      chk(wip, w, "no jumper");
      summarize();
   end
endmodule : pneumatic_control_latch_bench
